// *** pkg/io_space_regs.vh ***
// Address map, field masks and access codes of the core's I/O register space.
`ifndef IO_SPACE_REGS_VH
`define IO_SPACE_REGS_VH

// ------------------------------------------------------------
// Address paths
// ------------------------------------------------------------
`define IO_SHORT_TO_DATA 8'h20
`define IO_BIT_RANGE_TOP 6'h1F
`define IO_EXT_FIRST 8'h60

// ------------------------------------------------------------
// Short port operation codes
// ------------------------------------------------------------
`define OP_READ 3'h0
`define OP_WRITE 3'h1
`define OP_SET_BIT 3'h2
`define OP_CLR_BIT 3'h3
`define OP_TEST_BIT 3'h4

// ------------------------------------------------------------
// Data-space addresses
// ------------------------------------------------------------
`define A_PC_FLAGS 8'h3B
`define A_TIMER_PRESCALER_GENERAL_CTRL 8'h43
`define A_TIMER0_CTRL_A 8'h44
`define A_TIMER0_CTRL_B 8'h45
`define A_TIMER0_COUNT 8'h46
`define A_TIMER0_COMPARE_A 8'h47
`define A_TIMER0_COMPARE_B 8'h48
`define A_SCRATCH_REG_ONE 8'h4A
`define A_SCRATCH_REG_TWO 8'h4B
`define A_SERIAL_PERIPH_CTRL 8'h4C
`define A_SERIAL_PERIPH_STATUS 8'h4D
`define A_SERIAL_PERIPH_DATA 8'h4E
`define A_COMPARATOR_CTRL_STATUS 8'h50
`define A_SLEEP_MODE_CTRL 8'h53
`define A_RESET_CAUSE_STATUS 8'h54
`define A_CORE_MISC_CTRL 8'h55
`define A_SELF_PROGRAM_CTRL 8'h57
`define A_STACK_POINTER_LOW 8'h5D
`define A_STACK_POINTER_HIGH 8'h5E
`define A_CORE_STATUS_FLAGS 8'h5F
`define A_WATCHDOG_CTRL_STATUS 8'h60
`define A_CLOCK_DIVIDER_CTRL 8'h61
`define A_POWER_REDUCTION_CTRL 8'h64
`define A_OSCILLATOR_TRIM 8'h66
`define A_PIN_CHANGE_INT_CTRL 8'h68

// ------------------------------------------------------------
// Implemented bits per register
// ------------------------------------------------------------
`define M_PC_FLAGS 8'h07
`define M_TIMER_PRESCALER_GENERAL_CTRL 8'h83
`define M_TIMER0_CTRL_A 8'hF3
`define M_TIMER0_CTRL_B 8'hCF
`define M_FULL 8'hFF
`define M_SERIAL_PERIPH_STATUS 8'hC1
`define M_SLEEP_MODE_CTRL 8'h0F
`define M_RESET_CAUSE_STATUS 8'h0F
`define M_CORE_MISC_CTRL 8'h73
`define M_SELF_PROGRAM_CTRL 8'hDF
`define M_STACK_POINTER_HIGH 8'h07
`define M_CLOCK_DIVIDER_CTRL 8'h8F
`define M_POWER_REDUCTION_CTRL 8'hEF
`define M_PIN_CHANGE_INT_CTRL 8'h07

// ------------------------------------------------------------
// Special fields
// ------------------------------------------------------------
`define W1C_PC_FLAGS 8'h07
`define W1C_COMPARATOR_EVENT 8'h10
`define W1C_WATCHDOG_EVENT 8'h80
`define RO_COMPARATOR_LEVEL 8'h20
`define POS_COMPARATOR_EVENT 4
`define POS_COMPARATOR_LEVEL 5
`define POS_WATCHDOG_EVENT 7

// ------------------------------------------------------------
// Reset value
// ------------------------------------------------------------
`define IO_RESET_VAL 8'h00

`endif

// *** rtl/io_register_space_decode.v ***
// Register bank and address decoding of the core's 8-bit I/O register space.
//
// How it works
// R1: Software writes zero to reserved bits; hardware stores nothing there anyway.
// R2: The core never writes reserved locations; such writes are simply dropped.
// R3: Short addresses 0x00 to 0x1F accept single-bit set and clear operations.
// R4: Short addresses 0x00 to 0x1F let the core test one bit for skips.
// R5: Some status flags clear when written with one; writing zero keeps them.
// R6: Bit set and clear touch only the addressed bit, never other flags.
// R7: The short port reaches 64 locations through a 6-bit address 0x00 to 0x3F.
// R8: Data-space accesses see each short register at its address plus 0x20.
// R9: Extended registers 0x60 to 0xFF answer only data-space loads and stores.
// R10: Reserved locations and bits read zero and ignore writes.
`timescale 1ns/1ps
`default_nettype none
`include "io_space_regs.vh"

module io_register_space_decode (
   // Clock and reset.
   input wire clk,
   input wire nrst,
   // Short I/O port of the core.
   input wire ioEn,
   input wire [2:0] ioOp,
   input wire [5:0] ioAddr,
   input wire [2:0] ioBit,
   // Data-space load and store port of the core.
   input wire dsRd,
   input wire dsWr,
   input wire [7:0] dsAddr,
   // Write data shared by both ports.
   input wire [7:0] wrData,
   // Hardware events and levels from the peripherals.
   input wire [2:0] pcEvent,
   input wire acEvent,
   input wire acLevel,
   input wire wdEvent,
   // Answers to the core.
   output reg [7:0] rdData_q,
   output reg rdValid_q,
   output reg bitTrue_q,
   output reg bitValid_q,
   // Register contents toward the peripherals, eight bits per entry.
   output wire [25*8-1:0] regView
);

   localparam NREG = 25;

   // ------------------------------------------------------------
   // Register table
   // ------------------------------------------------------------

   // Data-space address of each entry.
   function [7:0] entryAddr;
      input integer i;
      begin
         case (i)
            0: entryAddr = `A_PC_FLAGS;
            1: entryAddr = `A_TIMER_PRESCALER_GENERAL_CTRL;
            2: entryAddr = `A_TIMER0_CTRL_A;
            3: entryAddr = `A_TIMER0_CTRL_B;
            4: entryAddr = `A_TIMER0_COUNT;
            5: entryAddr = `A_TIMER0_COMPARE_A;
            6: entryAddr = `A_TIMER0_COMPARE_B;
            7: entryAddr = `A_SCRATCH_REG_ONE;
            8: entryAddr = `A_SCRATCH_REG_TWO;
            9: entryAddr = `A_SERIAL_PERIPH_CTRL;
            10: entryAddr = `A_SERIAL_PERIPH_STATUS;
            11: entryAddr = `A_SERIAL_PERIPH_DATA;
            12: entryAddr = `A_COMPARATOR_CTRL_STATUS;
            13: entryAddr = `A_SLEEP_MODE_CTRL;
            14: entryAddr = `A_RESET_CAUSE_STATUS;
            15: entryAddr = `A_CORE_MISC_CTRL;
            16: entryAddr = `A_SELF_PROGRAM_CTRL;
            17: entryAddr = `A_STACK_POINTER_LOW;
            18: entryAddr = `A_STACK_POINTER_HIGH;
            19: entryAddr = `A_CORE_STATUS_FLAGS;
            20: entryAddr = `A_WATCHDOG_CTRL_STATUS;
            21: entryAddr = `A_CLOCK_DIVIDER_CTRL;
            22: entryAddr = `A_POWER_REDUCTION_CTRL;
            23: entryAddr = `A_OSCILLATOR_TRIM;
            default: entryAddr = `A_PIN_CHANGE_INT_CTRL;
         endcase
      end
   endfunction

   // Implemented bits of each entry; the rest are reserved.
   function [7:0] entryMask;
      input integer i;
      begin
         case (i)
            0: entryMask = `M_PC_FLAGS;
            1: entryMask = `M_TIMER_PRESCALER_GENERAL_CTRL;
            2: entryMask = `M_TIMER0_CTRL_A;
            3: entryMask = `M_TIMER0_CTRL_B;
            10: entryMask = `M_SERIAL_PERIPH_STATUS;
            13: entryMask = `M_SLEEP_MODE_CTRL;
            14: entryMask = `M_RESET_CAUSE_STATUS;
            15: entryMask = `M_CORE_MISC_CTRL;
            16: entryMask = `M_SELF_PROGRAM_CTRL;
            18: entryMask = `M_STACK_POINTER_HIGH;
            21: entryMask = `M_CLOCK_DIVIDER_CTRL;
            22: entryMask = `M_POWER_REDUCTION_CTRL;
            24: entryMask = `M_PIN_CHANGE_INT_CTRL;
            default: entryMask = `M_FULL;
         endcase
      end
   endfunction

   // Flags of each entry that clear on a written one.
   function [7:0] entryW1c;
      input integer i;
      begin
         case (i)
            0: entryW1c = `W1C_PC_FLAGS;
            12: entryW1c = `W1C_COMPARATOR_EVENT;
            20: entryW1c = `W1C_WATCHDOG_EVENT;
            default: entryW1c = 8'h00;
         endcase
      end
   endfunction

   // Bits of each entry that only mirror a peripheral level.
   function [7:0] entryRo;
      input integer i;
      begin
         case (i)
            12: entryRo = `RO_COMPARATOR_LEVEL;
            default: entryRo = 8'h00;
         endcase
      end
   endfunction

   // ------------------------------------------------------------
   // Access decode
   // ------------------------------------------------------------

   // A short address is moved into data space by the fixed offset; 0x3F lands on 0x5F.
   wire [7:0] ioDataAddr = {2'h0, ioAddr} + `IO_SHORT_TO_DATA; // [R7] [R8]
   // The short port wins if both ports are driven; its top lies below 0x60.
   wire [7:0] effAddr = ioEn ? ioDataAddr : dsAddr; // [R9]
   wire isRead = ioEn ? (ioOp == `OP_READ) : dsRd;
   wire isWrite = ioEn ? (ioOp == `OP_WRITE) : dsWr;
   // Bit operations exist only for the low short range.
   wire bitOk = ioEn && (ioAddr <= `IO_BIT_RANGE_TOP); // [R3] [R4]
   wire isSet = bitOk && (ioOp == `OP_SET_BIT); // [R3]
   wire isClr = bitOk && (ioOp == `OP_CLR_BIT); // [R3]
   wire isTest = bitOk && (ioOp == `OP_TEST_BIT); // [R4]
   // Level copied into the read-only comparator bit.
   wire [7:0] roLevel = {2'h0, acLevel, 5'h00};

   wire [NREG-1:0] hit;

   // ------------------------------------------------------------
   // Register entries
   // ------------------------------------------------------------

   genvar g;
   generate
      for (g = 0; g < NREG; g = g + 1) begin : entry
         localparam [7:0] ADDR = entryAddr(g);
         localparam [7:0] MASK = entryMask(g);
         localparam [7:0] W1C = entryW1c(g);
         localparam [7:0] RO = entryRo(g);
         localparam [7:0] PLAIN = MASK & ~W1C & ~RO;
         reg [7:0] val_q;
         reg [7:0] val_d;
         reg [7:0] hwSet;

         assign hit[g] = (effAddr == ADDR);
         assign regView[g*8 +: 8] = val_q;

         // Hardware events that raise flags in this entry.
         always @* begin
            hwSet = 8'h00;
            if (ADDR == `A_PC_FLAGS) begin
               hwSet = {5'h00, pcEvent};
            end else if (ADDR == `A_COMPARATOR_CTRL_STATUS) begin
               hwSet[`POS_COMPARATOR_EVENT] = acEvent;
            end else if (ADDR == `A_WATCHDOG_CTRL_STATUS) begin
               hwSet[`POS_WATCHDOG_EVENT] = wdEvent;
            end
         end

         // Next value: core access first, then events, then masking.
         always @* begin
            val_d = val_q;
            if (hit[g] && isWrite) begin
               // Plain bits take the data; flags clear where a one is written.
               val_d = (wrData & PLAIN) | (val_q & W1C & ~wrData); // [R5] [R1]
            end else if (hit[g] && isSet) begin
               // A set on a flag is a written one, so it clears that flag alone.
               if (W1C[ioBit]) begin
                  val_d[ioBit] = 1'b0; // [R5] [R6]
               end else if (PLAIN[ioBit]) begin
                  val_d[ioBit] = 1'b1; // [R6]
               end
            end else if (hit[g] && isClr) begin
               // A clear writes zero, which leaves flags as they are.
               if (PLAIN[ioBit]) begin
                  val_d[ioBit] = 1'b0; // [R6]
               end
            end
            // An event in the clearing cycle is kept.
            val_d = val_d | (hwSet & W1C);
            val_d = (val_d & ~RO) | (roLevel & RO);
            // Reserved bits never hold a one.
            val_d = val_d & MASK; // [R10]
         end

         // Storage of this entry.
         always @(posedge clk or negedge nrst) begin
            if (!nrst) begin
               val_q <= `IO_RESET_VAL;
            end else begin
               val_q <= val_d;
            end
         end
      end
   endgenerate

   // ------------------------------------------------------------
   // Read path
   // ------------------------------------------------------------

   reg [7:0] rdMux;
   integer k;

   // Selects the addressed entry; unmapped locations give zero.
   always @* begin
      rdMux = 8'h00; // [R10] [R2]
      for (k = 0; k < NREG; k = k + 1) begin
         if (hit[k]) begin
            rdMux = regView[k*8 +: 8];
         end
      end
   end

   // Registered answers, one cycle after the request.
   always @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         rdData_q <= 8'h00;
         rdValid_q <= 1'b0;
         bitTrue_q <= 1'b0;
         bitValid_q <= 1'b0;
      end else begin
         rdValid_q <= isRead;
         bitValid_q <= isTest;
         if (isRead) begin
            rdData_q <= rdMux;
         end
         if (isTest) begin
            bitTrue_q <= rdMux[ioBit]; // [R4]
         end
      end
   end

endmodule

`default_nettype wire

// *** verification/io_space_checker_asserts.sv ***
// Port assertions for the I/O register space decoder.
`timescale 1ns/1ps
`default_nettype none
`include "io_space_regs.vh"
module io_space_checker (
   // Clock and reset.
   input wire clk,
   input wire nrst,
   // Core requests.
   input wire ioEn,
   input wire [2:0] ioOp,
   input wire [5:0] ioAddr,
   input wire [2:0] ioBit,
   input wire dsRd,
   input wire dsWr,
   input wire [7:0] dsAddr,
   input wire [7:0] wrData,
   // Peripheral events.
   input wire [2:0] pcEvent,
   input wire wdEvent,
   // Answers and register view.
   input wire rdValid_q,
   input wire bitTrue_q,
   input wire bitValid_q,
   input wire [199:0] regView
);
   default clocking @(posedge clk); endclocking
   default disable iff (!nrst);
   a_io_read_answer: assert property (ioEn && ioOp == `OP_READ |=> rdValid_q)
      else $error("short read gave no answer");
   a_ds_read_answer: assert property (!ioEn && dsRd |=> rdValid_q)
      else $error("data read gave no answer");
   a_valid_has_cause: assert property (rdValid_q |-> $past(ioEn && ioOp == `OP_READ || !ioEn && dsRd))
      else $error("read answer without request");
   a_test_range: assert property (ioEn && ioOp == `OP_TEST_BIT |=> bitValid_q == ($past(ioAddr) <= 6'h1F))
      else $error("bit test answer wrong for address");
   a_test_value: assert property (ioEn && ioOp == `OP_TEST_BIT && ioAddr == 6'h1B && ioBit == 3'h0
      |=> bitTrue_q == $past(regView[0]))
      else $error("bit test value wrong");
   a_w1c_clears: assert property (!ioEn && dsWr && dsAddr == `A_PC_FLAGS && wrData[0] && !pcEvent[0]
      |=> !regView[0])
      else $error("flag not cleared by one");
   a_w1c_zero_keeps: assert property (!ioEn && dsWr && dsAddr == `A_PC_FLAGS && !wrData[0] && regView[0]
      |=> regView[0])
      else $error("flag lost on zero write");
   a_setbit_alone: assert property (ioEn && ioOp == `OP_SET_BIT && ioBit == 3'h1 && !pcEvent[0]
      |=> $stable(regView[0]))
      else $error("bit op touched another flag");
   a_bitop_range: assert property (ioEn && ioOp inside {`OP_SET_BIT, `OP_CLR_BIT} && ioAddr == 6'h2A
      |=> $stable(regView[63:56]))
      else $error("bit op above range took effect");
   a_short_offset: assert property (ioEn && ioOp == `OP_WRITE && ioAddr == 6'h2A
      |=> regView[63:56] == $past(wrData))
      else $error("short write missed offset register");
   a_ext_unreachable: assert property (ioEn && !wdEvent |=> $stable(regView[167:160]))
      else $error("short port changed extended register");
   a_reserved_zero: assert property ((regView[15:8] & ~`M_TIMER_PRESCALER_GENERAL_CTRL) == 8'h00)
      else $error("reserved bits not zero");
endmodule
bind io_register_space_decode io_space_checker chk (.clk(clk), .nrst(nrst), .ioEn(ioEn), .ioOp(ioOp),
   .ioAddr(ioAddr), .ioBit(ioBit), .dsRd(dsRd), .dsWr(dsWr), .dsAddr(dsAddr), .wrData(wrData),
   .pcEvent(pcEvent), .wdEvent(wdEvent), .rdValid_q(rdValid_q), .bitTrue_q(bitTrue_q),
   .bitValid_q(bitValid_q), .regView(regView));
`default_nettype wire

// *** verification/core_bus_model.sv ***
// Behavioural model of the processor core issuing register accesses.
`timescale 1ns/1ps
`default_nettype none
module core_bus_model (
   // Clock.
   input wire logic clk,
   // Requests.
   output logic ioEn,
   output logic [2:0] ioOp,
   output logic [5:0] ioAddr,
   output logic [2:0] ioBit,
   output logic dsRd,
   output logic dsWr,
   output logic [7:0] dsAddr,
   output logic [7:0] wrData,
   // Answers.
   input wire logic [7:0] rdData_q,
   input wire logic rdValid_q,
   input wire logic bitTrue_q,
   input wire logic bitValid_q
);
   // Idle at time zero.
   initial begin
      {ioEn, ioOp, ioAddr, ioBit, dsRd, dsWr, dsAddr, wrData} = '0;
   end
   // One access by data address; the short port gets it minus the offset
   // and writes carry only what the caller commands.
   task automatic access(input logic io, input logic [2:0] op, input logic [7:0] a, input logic [2:0] b,
      input logic [7:0] d, output logic [7:0] rd, output logic vld, output logic bt, output logic bvld);
      logic [7:0] sa;
      sa = a - `IO_SHORT_TO_DATA;
      @(posedge clk);
      #1;
      {ioEn, ioOp, ioAddr, ioBit} = {io, op, sa[5:0], b};
      {dsRd, dsWr, dsAddr, wrData} = {!io && op == `OP_READ, !io && op == `OP_WRITE, a, d};
      @(posedge clk);
      #1;
      {ioEn, dsRd, dsWr} = 3'h0;
      {ioOp, ioAddr, ioBit, dsAddr, wrData} = ~{ioOp, ioAddr, ioBit, dsAddr, wrData};
      {rd, vld, bt, bvld} = {rdData_q, rdValid_q, bitTrue_q, bitValid_q};
   endtask
endmodule
`default_nettype wire

// *** verification/io_register_space_decode_test.sv ***
// Self-checking testbench of the I/O register space decoder.
`timescale 1ns/1ps
`default_nettype none
`include "io_space_regs.vh"
module io_register_space_decode_test;
   logic clk, nrst, acEvent, acLevel, wdEvent, ioEn, dsRd, dsWr, rdValid_q, bitTrue_q, bitValid_q, vld, bt, bvld;
   logic [2:0] pcEvent, ioOp, ioBit;
   logic [5:0] ioAddr;
   logic [7:0] dsAddr, wrData, rdData_q, rd, d;
   logic [199:0] regView;
   integer errors = 0, checks_done = 0, seed = 32'h236666ea, i;
   io_register_space_decode DUT (.clk(clk), .nrst(nrst), .ioEn(ioEn), .ioOp(ioOp), .ioAddr(ioAddr),
      .ioBit(ioBit), .dsRd(dsRd), .dsWr(dsWr), .dsAddr(dsAddr), .wrData(wrData), .pcEvent(pcEvent),
      .acEvent(acEvent), .acLevel(acLevel), .wdEvent(wdEvent), .rdData_q(rdData_q), .rdValid_q(rdValid_q),
      .bitTrue_q(bitTrue_q), .bitValid_q(bitValid_q), .regView(regView));
   core_bus_model core (.clk(clk), .ioEn(ioEn), .ioOp(ioOp), .ioAddr(ioAddr), .ioBit(ioBit), .dsRd(dsRd),
      .dsWr(dsWr), .dsAddr(dsAddr), .wrData(wrData), .rdData_q(rdData_q), .rdValid_q(rdValid_q),
      .bitTrue_q(bitTrue_q), .bitValid_q(bitValid_q));
   // Free-running clock.
   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end
   task chk8(input string w, input logic [7:0] e, input logic [7:0] g);
      checks_done++;
      if (g !== e) begin
         errors++;
         $display("unexpected %s: expected %h seen %h", w, e, g);
      end
   endtask
   task chk1(input string w, input logic e, input logic g);
      chk8(w, {7'h00, e}, {7'h00, g});
   endtask
   task op(input logic io, input logic [2:0] c, input logic [7:0] a, input logic [2:0] b, input logic [7:0] v);
      core.access(io, c, a, b, v, rd, vld, bt, bvld);
   endtask
   // Implemented bits of each data address but 0x3B, 0x50 and 0x60; those and all else give zero.
   function automatic logic [7:0] mask(input logic [7:0] a);
      case (a)
         8'h43: mask = 8'h83;
         8'h44: mask = 8'hF3;
         8'h45: mask = 8'hCF;
         8'h4D: mask = 8'hC1;
         8'h53, 8'h54: mask = 8'h0F;
         8'h55: mask = 8'h73;
         8'h57: mask = 8'hDF;
         8'h5E, 8'h68: mask = 8'h07;
         8'h61: mask = 8'h8F;
         8'h64: mask = 8'hEF;
         8'h46, 8'h47, 8'h48, 8'h4A, 8'h4B, 8'h4C, 8'h4E, 8'h5D, 8'h5F, 8'h66: mask = 8'hFF;
         default: mask = 8'h00;
      endcase
   endfunction
   task test_done;
      $display("checks %0d errors %0d", checks_done, errors);
      if (errors == 0 && checks_done > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask
   // Cuts a hang short.
   initial begin
      repeat (5000) @(posedge clk);
      errors++;
      test_done;
   end
   // Main sequence: reset, register sweep, then flag handling.
   initial begin
      {nrst, pcEvent, acEvent, acLevel, wdEvent} = '0;
      repeat (12) @(posedge clk);
      #1 nrst = 1'b1;
      for (i = 0; i < 25; i++) chk8("reset value", 8'h00, regView[i*8 +: 8]);
      for (i = 8'h43; i <= 8'h68; i++) if (i != 8'h50 && i != 8'h60) begin
         // The core keeps reserved bits at zero and never writes a reserved location.
         d = $random(seed);
         d = d & mask(i[7:0]);
         if (mask(i[7:0]) != 8'h00) op(i < 8'h60 && d[0], `OP_WRITE, i[7:0], 3'h0, d);
         op(i < 8'h60 && !d[0], `OP_READ, i[7:0], 3'h0, 8'h00);
         chk8("register", d & mask(i[7:0]), rd);
         chk1("read answer", 1'b1, vld);
      end
      @(posedge clk);
      #1 {pcEvent, acEvent, acLevel, wdEvent} = 6'h3F;
      @(posedge clk);
      #1 {pcEvent, acEvent, wdEvent} = 5'h00;
      for (i = 0; i < 3; i++) begin
         op(1'b1, `OP_TEST_BIT, `A_PC_FLAGS, i[2:0], 8'h00);
         chk1("flag test", 1'b1, bt && bvld);
      end
      op(1'b1, `OP_SET_BIT, `A_PC_FLAGS, 3'h1, 8'h00);
      op(1'b1, `OP_CLR_BIT, `A_PC_FLAGS, 3'h0, 8'h00);
      op(1'b0, `OP_WRITE, `A_PC_FLAGS, 3'h0, 8'h00);
      op(1'b1, `OP_READ, `A_PC_FLAGS, 3'h0, 8'h00);
      chk8("flags", 8'h05, rd);
      op(1'b0, `OP_WRITE, `A_PC_FLAGS, 3'h0, 8'h05);
      op(1'b0, `OP_READ, `A_PC_FLAGS, 3'h0, 8'h00);
      chk8("flags cleared", 8'h00, rd);
      op(1'b1, `OP_WRITE, `A_SCRATCH_REG_ONE, 3'h0, 8'h00);
      op(1'b1, `OP_SET_BIT, `A_SCRATCH_REG_ONE, 3'h3, 8'h00);
      op(1'b1, `OP_TEST_BIT, `A_SCRATCH_REG_ONE, 3'h3, 8'h00);
      chk1("test above range", 1'b0, bvld);
      op(1'b0, `OP_READ, `A_SCRATCH_REG_ONE, 3'h0, 8'h00);
      chk8("set above range", 8'h00, rd);
      op(1'b1, `OP_READ, `A_COMPARATOR_CTRL_STATUS, 3'h0, 8'h00);
      chk8("comparator", 8'h30, rd);
      op(1'b0, `OP_WRITE, `A_COMPARATOR_CTRL_STATUS, 3'h0, 8'h10);
      op(1'b0, `OP_READ, `A_COMPARATOR_CTRL_STATUS, 3'h0, 8'h00);
      chk8("comparator cleared", 8'h20, rd);
      op(1'b0, `OP_READ, `A_WATCHDOG_CTRL_STATUS, 3'h0, 8'h00);
      chk8("watchdog", 8'h80, rd);
      op(1'b0, `OP_WRITE, `A_WATCHDOG_CTRL_STATUS, 3'h0, 8'h80);
      op(1'b0, `OP_READ, `A_WATCHDOG_CTRL_STATUS, 3'h0, 8'h00);
      chk8("watchdog cleared", 8'h00, rd);
      test_done;
   end
endmodule
`default_nettype wire
